//--- verilog/pmu_ctrl_regs.svh
// Purpose: Register map, defaults and timing constants of the PMU control bank.
// Assumes: Clock of 10 MHz; register index equals the serial sub-address.
// Notes: Default words pack register 0x00 in bits 7:0 up to pull-down register 0x0E in bits 119:112; the top byte is unused.
// Contract
// - Release from reset loads variant and pin selected defaults.
// - Converter enable arms startup or acts immediately.
// - Regulator enable arms startup or acts immediately.
// - Sleep bit places regulators in sleep.
// - Converter one set from bit or pin.
// - Converter two set chosen by register only.
// - Two bits pick 32, 64, 128, 256 us.
// - Delay code times step delays turn-on.
// - Delay code 111 means never started; the enable still turns it on once idle.
// - Regulator code maps 1.20V to 3.30V.
// - Low-input code maps 0.80V to 3.30V.
// - Converter code maps 0.80V to 3.00V.
// - Converter pull-down bit enables pull-down.
// - Forced fixed-frequency bit holds PWM operation.
// - Converter mask bit suppresses its OK flag.
// - First regulator mask suppresses its OK flag.
// - General register field positions fixed.
// - Output registers hold delay and voltage codes.
// - Pull-down register bits enable regulator pull-downs.
// - Status reports thermal trip and not-OK bits.
`ifndef PMU_CTRL_REGS_SVH
`define PMU_CTRL_REGS_SVH

`define ADDR_GENERAL 4'h0
`define ADDR_CONV_ONE_A 4'h8
`define ADDR_CONV_ONE_B 4'h9
`define ADDR_CONV_TWO_A 4'hA
`define ADDR_CONV_TWO_B 4'hB
`define ADDR_CONV_MODE 4'hC
`define ADDR_REG_ENABLE 4'hD
`define ADDR_PULLDOWN 4'hE
`define ADDR_STATUS 4'hF

`define GEN_LONG_BIT 7
`define GEN_HALVE_BIT 6
`define GEN_CONV_TWO_ON_BIT 4
`define GEN_CONV_TWO_SEL_BIT 3
`define GEN_CONV_ONE_SEL_BIT 2
`define GEN_SLEEP_BIT 1
`define GEN_CONV_ONE_ON_BIT 0
`define MODE_PDN_ONE_BIT 0
`define MODE_PWM_ONE_BIT 1
`define MODE_PDN_TWO_BIT 4
`define MODE_PWM_TWO_BIT 5
`define MODE_MASK_ONE_BIT 6
`define MODE_MASK_TWO_BIT 7
`define ENA_FIRST_MASK_BIT 7

`define WMASK_GENERAL 8'hDF
`define WMASK_CONV_B 8'hDF
`define WMASK_CONV_MODE 8'hF3
`define WMASK_FULL 8'hFF

`define RST_PULLDOWN 8'h7F
`define RST_STATUS 8'h00
`define CODE_NO_START 3'h7
`define LAST_STEP 3'h6

`define CLK_MHZ 10
`define STEP_US_A 32
`define STEP_US_B 64
`define STEP_US_C 128
`define STEP_US_D 256
`define STEP_CYC_A (`STEP_US_A * `CLK_MHZ)
`define STEP_CYC_B (`STEP_US_B * `CLK_MHZ)
`define STEP_CYC_C (`STEP_US_C * `CLK_MHZ)
`define STEP_CYC_D (`STEP_US_D * `CLK_MHZ)

`define DFLT_V0_HI 128'h007F_7F7F_9151_C804_48A8_999F_BF8C_9959
`define DFLT_V0_LO 128'h007F_7F11_9131_C408_083F_3959_5939_3559
`define DFLT_V1_HI 128'h007F_FBD1_84E6_C4E6_2410_193D_FF1D_1500
`define DFLT_V1_LO 128'h007F_FFD1_880A_C80A_B0B0_9999_7979_9951
`define DFLT_V2_HI 128'h007F_4111_9191_C808_DFF7_E0E0_F9F9_B5DD
`define DFLT_V2_LO 128'h007F_4111_9191_C808_DFF7_E0E0_F9F9_ACDD
`define DFLT_V3_HI 128'h007F_7F11_9151_C808_8888_5FB4_B999_95DD
`define DFLT_V3_LO 128'h007F_7F11_9151_C808_8888_5FB4_B999_95DD
`define DFLT_V4_HI 128'h007F_6411_D151_CA0A_5D5D_E0FD_4CEC_F99D
`define DFLT_V4_LO 128'h007F_6411_D151_CA0A_5D5D_ECFD_4CEC_F99D

`define MV_REGULATOR {128'h3300_3100_3000_2950_2900_2850_2800_2750, \
  128'h2700_2650_2600_2500_2400_2300_2200_2100, \
  128'h2000_1900_1850_1800_1750_1700_1650_1600, \
  128'h1550_1500_1450_1400_1350_1300_1250_1200}
`define MV_LOW_INPUT {128'h3300_3100_3000_2900_2850_2800_2700_2600, \
  128'h2500_2400_2300_2200_2100_2000_1900_1800, \
  128'h1700_1600_1500_1400_1350_1300_1250_1200, \
  128'h1150_1100_1050_1000_0950_0900_0850_0800}
`define MV_CONVERTER {128'h3000_2900_2850_2800_2700_2600_2500_2400, \
  128'h2300_2200_2100_2000_1900_1850_1800_1750, \
  128'h1700_1600_1500_1400_1350_1300_1250_1200, \
  128'h1150_1100_1050_1000_0950_0900_0850_0800}
`define MA_PEAK_LIMIT 64'h1370_1050_0780_0460

`endif

//--- verilog/pmu_ctrl_pkg.sv
// Purpose: Types shared by the PMU control bank.
// Assumes: Nine channels: five regulators, two low-input, two converters.
// Notes: All state lives in one packed struct.
package pmu_ctrl_pkg;

  typedef enum logic [2:0]
  {
    SEQ_OFF = 3'b001,
    SEQ_RUN = 3'b010,
    SEQ_IDLE = 3'b100
  } seq_state_t;

  typedef struct packed
  {
    seq_state_t seq;
    logic load_pend;
    logic [14:0][7:0] regs;
    logic [7:0] status;
    logic [7:0] rdata;
    logic [11:0] step_cyc;
    logic [2:0] step_idx;
    logic [8:0] on;
    logic [8:0][15:0] mv;
    logic [1:0][15:0] peak;
    logic [9:0] conv_code;
    logic [2:0] ok_flag;
  } state_t;

endpackage

//--- verilog/pmu_ctrl_bank.sv
// Purpose: Control register bank and startup sequencer of the PMU.
// Assumes: The serial front end presents decoded byte reads and writes.
// Notes: Channel order is regulators 0-4, low-input 5-6, converters 7-8.
`timescale 1ns/100ps
`include "pmu_ctrl_regs.svh"
module pmu_ctrl_bank
#(
  parameter int VARIANT = 0,
  parameter logic [3:0] REVISION = 4'h0
)
(
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  input wire logic DEFAULT_SET_PIN_I,
  input wire logic VOLTAGE_SET_SELECT_PIN_I,
  input wire logic ACTIVE_REQ_I,
  input wire logic REG_WRITE_I,
  input wire logic REG_READ_I,
  input wire logic [3:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic THERMAL_TRIP_FLAG_I,
  input wire logic [1:0] CONVERTER_OUT_OF_REGULATION_I,
  input wire logic REGULATOR_OUT_OF_REGULATION_I,
  output logic [7:0] REG_RDATA_O,
  output logic [8:0] CHANNEL_ON_O,
  output logic [143:0] CHANNEL_MV_BCD_O,
  output logic [9:0] CONVERTER_VOLTAGE_CODE_O,
  output logic [3:0] CONVERTER_PEAK_LIMIT_O,
  output logic [31:0] CONVERTER_PEAK_MA_BCD_O,
  output logic [1:0] CONVERTER_PULLDOWN_ON_O,
  output logic [1:0] CONVERTER_FORCE_FIXED_FREQ_O,
  output logic [6:0] REGULATOR_PULLDOWN_ON_O,
  output logic REGULATOR_SLEEP_O,
  output logic [1:0] CONVERTER_OK_O,
  output logic FIRST_REGULATOR_OK_O,
  output logic [1:0] SEQ_STATE_IDLE_RUN_O
);
  import pmu_ctrl_pkg::*;

  // Pull-down register comes up at its fixed value; the rest waits for the
  // load that follows release, since the strap may not be read in reset.
  localparam state_t ST_RST = '{
    seq: SEQ_OFF,
    load_pend: 1'b1,
    regs: {`RST_PULLDOWN, 112'h0},
    status: `RST_STATUS,
    default: '0
  };

  state_t st_ff;
  state_t nxt_st;

  logic [8:0] en_w;
  logic [8:0][2:0] code_w;
  logic [8:0] start_w;
  logic [8:0][15:0] mv_w;
  logic [4:0] conv_one_code;
  logic [4:0] conv_two_code;
  logic [11:0] step_len;
  logic [127:0] dflt_w;

  // Tables live in constants because a literal cannot be part-selected.
  localparam logic [511:0] MV_REG_TAB = `MV_REGULATOR;
  localparam logic [511:0] MV_LOW_TAB = `MV_LOW_INPUT;
  localparam logic [511:0] MV_CONV_TAB = `MV_CONVERTER;
  localparam logic [63:0] MA_PEAK_TAB = `MA_PEAK_LIMIT;

  function automatic logic [127:0] dflt(input logic pin_high);
    logic [127:0] d;
    d = pin_high ? `DFLT_V0_HI : `DFLT_V0_LO;
    case (VARIANT)
      1: d = pin_high ? `DFLT_V1_HI : `DFLT_V1_LO;
      2: d = pin_high ? `DFLT_V2_HI : `DFLT_V2_LO;
      3: d = pin_high ? `DFLT_V3_HI : `DFLT_V3_LO;
      4: d = pin_high ? `DFLT_V4_HI : `DFLT_V4_LO;
      default: d = pin_high ? `DFLT_V0_HI : `DFLT_V0_LO;
    endcase
    return d;
  endfunction

  function automatic logic [7:0] wmask(input logic [3:0] addr);
    logic [7:0] m;
    m = `WMASK_FULL;
    case (addr)
      `ADDR_GENERAL: m = `WMASK_GENERAL;
      `ADDR_CONV_ONE_B: m = `WMASK_CONV_B;
      `ADDR_CONV_TWO_B: m = `WMASK_CONV_B;
      `ADDR_CONV_MODE: m = `WMASK_CONV_MODE;
      default: m = `WMASK_FULL;
    endcase
    return m;
  endfunction

  assign dflt_w = dflt(DEFAULT_SET_PIN_I);

  assign conv_one_code =
    (st_ff.regs[`ADDR_GENERAL][`GEN_CONV_ONE_SEL_BIT] ||
     VOLTAGE_SET_SELECT_PIN_I) ?
    st_ff.regs[`ADDR_CONV_ONE_A][4:0] : st_ff.regs[`ADDR_CONV_ONE_B][4:0];
  assign conv_two_code = st_ff.regs[`ADDR_GENERAL][`GEN_CONV_TWO_SEL_BIT] ?
    st_ff.regs[`ADDR_CONV_TWO_A][4:0] : st_ff.regs[`ADDR_CONV_TWO_B][4:0];

  always_comb
  begin
    case (st_ff.regs[`ADDR_GENERAL][`GEN_LONG_BIT:`GEN_HALVE_BIT])
      2'b00: step_len = 12'(`STEP_CYC_A);
      2'b01: step_len = 12'(`STEP_CYC_B);
      2'b10: step_len = 12'(`STEP_CYC_C);
      default: step_len = 12'(`STEP_CYC_D);
    endcase
  end

  genvar ch;
  generate
    for (ch = 0; ch < 9; ch++)
    begin : g_chan
      if (ch < 7)
      begin : g_lin
        assign en_w[ch] = st_ff.regs[`ADDR_REG_ENABLE][ch];
        assign code_w[ch] = st_ff.regs[ch + 1][7:5];
      end
      else if (ch == 7)
      begin : g_c1
        assign en_w[ch] = st_ff.regs[`ADDR_GENERAL][`GEN_CONV_ONE_ON_BIT];
        assign code_w[ch] = st_ff.regs[`ADDR_CONV_ONE_A][7:5];
      end
      else
      begin : g_c2
        assign en_w[ch] = st_ff.regs[`ADDR_GENERAL][`GEN_CONV_TWO_ON_BIT];
        assign code_w[ch] = st_ff.regs[`ADDR_CONV_TWO_A][7:5];
      end
      assign start_w[ch] = en_w[ch] && (code_w[ch] != `CODE_NO_START) &&
        (code_w[ch] <= st_ff.step_idx);
      if (ch < 5)
      begin : g_mv_reg
        assign mv_w[ch] =
          MV_REG_TAB[{st_ff.regs[ch + 1][4:0], 4'h0} +: 16];
      end
      else if (ch < 7)
      begin : g_mv_low
        assign mv_w[ch] =
          MV_LOW_TAB[{st_ff.regs[ch + 1][4:0], 4'h0} +: 16];
      end
      else
      begin : g_mv_conv
        assign mv_w[ch] = MV_CONV_TAB[
          {(ch == 7) ? conv_one_code : conv_two_code, 4'h0} +: 16];
      end
    end
  endgenerate

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.status = {REVISION, REGULATOR_OUT_OF_REGULATION_I,
                     CONVERTER_OUT_OF_REGULATION_I, THERMAL_TRIP_FLAG_I};
    if (st_ff.load_pend)
    begin
      nxt_st.regs = dflt_w[119:0];
      nxt_st.load_pend = 1'b0;
    end
    else if (REG_WRITE_I && (REG_ADDR_I != `ADDR_STATUS))
    begin
      nxt_st.regs[REG_ADDR_I] = REG_WDATA_I & wmask(REG_ADDR_I);
    end
    if (REG_READ_I)
    begin
      nxt_st.rdata = (REG_ADDR_I == `ADDR_STATUS) ? st_ff.status :
        st_ff.regs[REG_ADDR_I];
    end
    case (st_ff.seq)
      SEQ_OFF:
      begin
        nxt_st.on = '0;
        nxt_st.step_cyc = '0;
        nxt_st.step_idx = '0;
        if (ACTIVE_REQ_I && !st_ff.load_pend)
        begin
          nxt_st.seq = SEQ_RUN;
        end
      end
      SEQ_RUN:
      begin
        nxt_st.on = st_ff.on | start_w;
        if (st_ff.step_idx == `LAST_STEP)
        begin
          nxt_st.seq = SEQ_IDLE;
        end
        else if (st_ff.step_cyc >= step_len - 12'h001)
        begin
          nxt_st.step_cyc = '0;
          nxt_st.step_idx = st_ff.step_idx + 3'h1;
        end
        else
        begin
          nxt_st.step_cyc = st_ff.step_cyc + 12'h001;
        end
        if (!ACTIVE_REQ_I)
        begin
          nxt_st.seq = SEQ_OFF;
          nxt_st.on = '0;
        end
      end
      SEQ_IDLE:
      begin
        nxt_st.on = en_w;
        // Standby drops every channel on the same edge as the state.
        if (!ACTIVE_REQ_I)
        begin
          nxt_st.seq = SEQ_OFF;
          nxt_st.on = '0;
        end
      end
      default:
      begin
        nxt_st.seq = SEQ_OFF;
        nxt_st.on = '0;
      end
    endcase
    nxt_st.mv = mv_w;
    nxt_st.conv_code = {conv_two_code, conv_one_code};
    nxt_st.peak[0] =
      MA_PEAK_TAB[{st_ff.regs[`ADDR_CONV_ONE_B][7:6], 4'h0} +: 16];
    nxt_st.peak[1] =
      MA_PEAK_TAB[{st_ff.regs[`ADDR_CONV_TWO_B][7:6], 4'h0} +: 16];
    nxt_st.ok_flag[0] = !CONVERTER_OUT_OF_REGULATION_I[0] &&
      !st_ff.regs[`ADDR_CONV_MODE][`MODE_MASK_ONE_BIT];
    nxt_st.ok_flag[1] = !CONVERTER_OUT_OF_REGULATION_I[1] &&
      !st_ff.regs[`ADDR_CONV_MODE][`MODE_MASK_TWO_BIT];
    nxt_st.ok_flag[2] = !REGULATOR_OUT_OF_REGULATION_I &&
      !st_ff.regs[`ADDR_REG_ENABLE][`ENA_FIRST_MASK_BIT];
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      st_ff <= ST_RST;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign REG_RDATA_O = st_ff.rdata;
  assign CHANNEL_ON_O = st_ff.on;
  assign CHANNEL_MV_BCD_O = st_ff.mv;
  assign CONVERTER_VOLTAGE_CODE_O = st_ff.conv_code;
  assign CONVERTER_PEAK_LIMIT_O = {st_ff.regs[`ADDR_CONV_TWO_B][7:6],
                                   st_ff.regs[`ADDR_CONV_ONE_B][7:6]};
  assign CONVERTER_PEAK_MA_BCD_O = st_ff.peak;
  assign CONVERTER_PULLDOWN_ON_O = {
    st_ff.regs[`ADDR_CONV_MODE][`MODE_PDN_TWO_BIT],
    st_ff.regs[`ADDR_CONV_MODE][`MODE_PDN_ONE_BIT]};
  assign CONVERTER_FORCE_FIXED_FREQ_O = {
    st_ff.regs[`ADDR_CONV_MODE][`MODE_PWM_TWO_BIT],
    st_ff.regs[`ADDR_CONV_MODE][`MODE_PWM_ONE_BIT]};
  assign REGULATOR_PULLDOWN_ON_O = st_ff.regs[`ADDR_PULLDOWN][6:0];
  assign REGULATOR_SLEEP_O = st_ff.regs[`ADDR_GENERAL][`GEN_SLEEP_BIT];
  assign CONVERTER_OK_O = st_ff.ok_flag[1:0];
  assign FIRST_REGULATOR_OK_O = st_ff.ok_flag[2];
  assign SEQ_STATE_IDLE_RUN_O = {st_ff.seq == SEQ_IDLE, st_ff.seq == SEQ_RUN};

endmodule

//--- tb/pmu_ctrl_bank_sva.sv
// Purpose: Port checker for the PMU control bank.
// Assumes: Writes count from the second edge after reset.
// Notes: Bound to every instance of the bank.
`timescale 1ns/100ps
module pmu_ctrl_bank_sva (
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  input wire logic ACTIVE_REQ_I,
  input wire logic REG_WRITE_I,
  input wire logic [3:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic [8:0] CHANNEL_ON_O,
  input wire logic [3:0] CONVERTER_PEAK_LIMIT_O,
  input wire logic [1:0] CONVERTER_PULLDOWN_ON_O,
  input wire logic [1:0] CONVERTER_FORCE_FIXED_FREQ_O,
  input wire logic [6:0] REGULATOR_PULLDOWN_ON_O,
  input wire logic REGULATOR_SLEEP_O,
  input wire logic [1:0] CONVERTER_OK_O,
  input wire logic [1:0] SEQ_STATE_IDLE_RUN_O
);
  logic up_ff;
  logic [4:0] wr_at;
  // The load edge after reset ignores writes, so it is kept out.
  assign wr_at = {REG_WRITE_I & up_ff, REG_ADDR_I};
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      up_ff <= 1'b0;
    else
      up_ff <= 1'b1;
  end
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_N_I);
  chk_conv_pulldown: assert property (
    wr_at == 5'h1C |=> CONVERTER_PULLDOWN_ON_O ==
    {$past(REG_WDATA_I[4]), $past(REG_WDATA_I[0])})
    else $error("converter pulldown wrong");
  chk_conv_fixed_freq: assert property (
    wr_at == 5'h1C |=> CONVERTER_FORCE_FIXED_FREQ_O ==
    {$past(REG_WDATA_I[5]), $past(REG_WDATA_I[1])})
    else $error("converter fixed frequency wrong");
  chk_reg_pulldown: assert property (
    wr_at == 5'h1E |=> REGULATOR_PULLDOWN_ON_O == $past(REG_WDATA_I[6:0]))
    else $error("regulator pulldown wrong");
  chk_sleep_bit: assert property (
    wr_at == 5'h10 |=> REGULATOR_SLEEP_O == $past(REG_WDATA_I[1]))
    else $error("sleep output wrong");
  chk_peak_limit: assert property (
    wr_at == 5'h19 |=> CONVERTER_PEAK_LIMIT_O[1:0] ==
    $past(REG_WDATA_I[7:6]))
    else $error("peak limit wrong");
  chk_conv_mask: assert property (
    (wr_at == 5'h1C && REG_WDATA_I[6]) ##1 wr_at != 5'h1C
    |=> !CONVERTER_OK_O[0])
    else $error("masked flag still set");
  chk_standby_off: assert property (
    !ACTIVE_REQ_I |=> SEQ_STATE_IDLE_RUN_O == 2'b00 && CHANNEL_ON_O == 9'h000)
    else $error("standby left channels on");
  chk_run_entry: assert property (
    SEQ_STATE_IDLE_RUN_O == 2'b01 && $past(SEQ_STATE_IDLE_RUN_O) == 2'b00
    |-> CHANNEL_ON_O == 9'h000)
    else $error("channel on at sequence start");
endmodule
bind pmu_ctrl_bank pmu_ctrl_bank_sva u_pmu_ctrl_bank_sva (
  .SYS_CLK_I(SYS_CLK_I), .RST_N_I(RST_N_I), .ACTIVE_REQ_I(ACTIVE_REQ_I),
  .REG_WRITE_I(REG_WRITE_I), .REG_ADDR_I(REG_ADDR_I),
  .REG_WDATA_I(REG_WDATA_I), .CHANNEL_ON_O(CHANNEL_ON_O),
  .CONVERTER_PEAK_LIMIT_O(CONVERTER_PEAK_LIMIT_O),
  .CONVERTER_PULLDOWN_ON_O(CONVERTER_PULLDOWN_ON_O),
  .CONVERTER_FORCE_FIXED_FREQ_O(CONVERTER_FORCE_FIXED_FREQ_O),
  .REGULATOR_PULLDOWN_ON_O(REGULATOR_PULLDOWN_ON_O),
  .REGULATOR_SLEEP_O(REGULATOR_SLEEP_O), .CONVERTER_OK_O(CONVERTER_OK_O),
  .SEQ_STATE_IDLE_RUN_O(SEQ_STATE_IDLE_RUN_O));

//--- tb/pmu_host_model.sv
// Purpose: Host side model that issues single byte register cycles.
// Assumes: Requests change on the falling edge only.
// Notes: After a request, idle address and data show its inverted values, zero before the first; write and read strobes drop to 0.
`timescale 1ns/100ps
module pmu_host_model (
  input wire logic clk_i,
  output logic wr_o,
  output logic rd_o,
  output logic [3:0] addr_o,
  output logic [7:0] data_o
);
  initial
  begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 4'h0;
    data_o = 8'h00;
  end
  task automatic xfer(input logic w, input logic [3:0] a,
                      input logic [7:0] d);
    @(negedge clk_i);
    wr_o = w;
    rd_o = !w;
    addr_o = a;
    data_o = d;
    @(negedge clk_i);
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = ~a;
    data_o = ~d;
  endtask
endmodule

//--- tb/pmu_ctrl_bank_tb.sv
// Purpose: Self-checking bench for the PMU control bank.
// Assumes: Base variant; strap high, then low for a second reset.
// Notes: Steps run at full length; the longest is 2560 cycles.
`timescale 1ns/100ps
module pmu_ctrl_bank_tb;
  logic clk, rst_n, act, vpin, thermal_trip_flag, roor, rd_seen, wr, rd, rok, sleep;
  logic [1:0] coor, seq, cok;
  logic dpin;
  logic [3:0] addr;
  logic [7:0] wd, rdat, d;
  logic [8:0] on;
  logic [143:0] mv;
  logic [9:0] vcode;
  logic [31:0] ma;
  logic [6:0] rpdn;
  int num_errors, n_checks, cyc, m, t0, t1, t2;
  logic [7:0] exp_q[$];
  pmu_host_model u_pmu_host_model (.clk_i(clk), .wr_o(wr), .rd_o(rd),
    .addr_o(addr), .data_o(wd));
  pmu_ctrl_bank u_pmu_ctrl_bank (.SYS_CLK_I(clk), .RST_N_I(rst_n),
    .DEFAULT_SET_PIN_I(dpin), .VOLTAGE_SET_SELECT_PIN_I(vpin),
    .ACTIVE_REQ_I(act), .REG_WRITE_I(wr), .REG_READ_I(rd),
    .REG_ADDR_I(addr), .REG_WDATA_I(wd), .THERMAL_TRIP_FLAG_I(thermal_trip_flag),
    .CONVERTER_OUT_OF_REGULATION_I(coor),
    .REGULATOR_OUT_OF_REGULATION_I(roor), .REG_RDATA_O(rdat),
    .CHANNEL_ON_O(on), .CHANNEL_MV_BCD_O(mv), .CONVERTER_VOLTAGE_CODE_O(vcode),
    .CONVERTER_PEAK_LIMIT_O(), .CONVERTER_PEAK_MA_BCD_O(ma),
    .CONVERTER_PULLDOWN_ON_O(), .CONVERTER_FORCE_FIXED_FREQ_O(),
    .REGULATOR_PULLDOWN_ON_O(rpdn), .REGULATOR_SLEEP_O(sleep),
    .CONVERTER_OK_O(cok), .FIRST_REGULATOR_OK_O(rok),
    .SEQ_STATE_IDLE_RUN_O(seq));
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk)
  begin
    rd_seen <= rd;
    cyc <= cyc + 1;
  end
  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] s);
    n_checks++;
    if (e !== s)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  // Read data is valid in the cycle after the read edge.
  always @(negedge clk)
  begin
    if (rd_seen === 1'b1)
      chk("read data", exp_q.pop_front(), rdat);
  end
  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic w(input logic [3:0] a, input logic [7:0] v);
    u_pmu_host_model.xfer(1'b1, a, v);
  endtask
  task automatic r(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_pmu_host_model.xfer(1'b0, a, 8'h00);
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wait_on(input int ch, output int t);
    int k;
    for (k = 0; k < 3000 && on[ch] !== 1'b1; k++)
      @(negedge clk);
    if (k == 3000)
    begin
      num_errors++;
      $display("MISMATCH channel %0d expected 1 seen 0", ch);
      final_report();
    end
    t = cyc;
  endtask
  initial
  begin
    {act, rst_n, cyc, num_errors, n_checks} = '0;
    {vpin, thermal_trip_flag, roor} = 3'b111;
    dpin = 1'b1;
    coor = 2'b10;
    d = 8'($urandom(32'h2619_8317));
    settle(6);
    chk("pulldown in reset", 16'h007F, rpdn);
    rst_n = 1'b1;
    r(4'h0, 8'h59);
    r(4'hD, 8'h7F);
    r(4'hE, 8'h7F);
    for (m = 1; m < 8; m++)
    begin
      d = 8'($urandom);
      w(m[3:0], d);
      r(m[3:0], d);
    end
    w(4'h9, d);
    r(4'h9, d & 8'hDF);
    w(4'h0, 8'hFF);
    chk("sleep", 16'h0001, sleep);
    r(4'h0, 8'hDF);
    w(4'h8, 8'h0A);
    w(4'h9, 8'h95);
    w(4'hA, 8'h03);
    w(4'hB, 8'h5C);
    w(4'h0, 8'h08);
    settle(3);
    chk("conv1 pin high", 16'h000A, vcode[4:0]);
    chk("conv2 set a", 16'h0003, vcode[9:5]);
    chk("conv1 mV", 16'h1300, mv[127:112]);
    chk("conv mA", 16'h1050, ma[15:0]);
    chk("conv2 mA", 16'h0780, ma[31:16]);
    vpin = 1'b0;
    settle(3);
    chk("conv1 pin low", 16'h0015, vcode[4:0]);
    chk("conv2 pin blind", 16'h0003, vcode[9:5]);
    chk("conv1 mV low", 16'h2100, mv[127:112]);
    w(4'h0, 8'h04);
    settle(3);
    chk("conv1 by bit", 16'h000A, vcode[4:0]);
    chk("conv2 set b", 16'h001C, vcode[9:5]);
    w(4'hC, 8'h30);
    settle(3);
    chk("conv ok", 16'h0001, cok);
    w(4'hC, 8'h43);
    w(4'hE, 8'h2A);
    settle(3);
    chk("conv ok masked", 16'h0000, cok);
    roor = 1'b0;
    // Channel three gets code 111, so its enable is kept clear.
    w(4'hD, 8'h77);
    settle(3);
    chk("ldo ok", 16'h0001, rok);
    w(4'hD, 8'hF7);
    w(4'hF, 8'hFF);
    settle(3);
    chk("ldo ok masked", 16'h0000, rok);
    r(4'hF, 8'h05);
    w(4'h1, 8'h28);
    w(4'h2, 8'h00);
    w(4'h3, 8'hC0);
    w(4'h4, 8'hE0);
    w(4'h6, 8'h0D);
    settle(3);
    chk("ldo mV", 16'h1600, mv[15:0]);
    chk("low input mV", 16'h1500, mv[95:80]);
    for (m = 0; m < 4; m++)
    begin
      // The first pass turns the first regulator off, so arm it again.
      w(4'hD, 8'hF7);
      w(4'h0, {m[1:0], 6'h11});
      act = 1'b1;
      wait_on(1, t0);
      wait_on(0, t1);
      chk("step", 16'(16'h0140 << m), 16'(t1 - t0));
      if (m == 0)
      begin
        wait_on(2, t2);
        chk("code six", 16'h0780, 16'(t2 - t0));
        settle(2);
        chk("no start", 16'h0000, on[3]);
        chk("idle", 16'h0002, seq);
        w(4'hD, 8'h76);
        settle(1);
        chk("ldo off", 16'h0000, on[0]);
        w(4'h0, 8'h10);
        settle(1);
        chk("conv off", 16'h0000, on[7]);
      end
      act = 1'b0;
      settle(2);
    end
    // A second reset with the strap low must load the other column.
    rst_n = 1'b0;
    dpin = 1'b0;
    settle(2);
    chk("pulldown in reset", 16'h007F, rpdn);
    rst_n = 1'b1;
    r(4'h1, 8'h35);
    r(4'hC, 8'h11);
    settle(2);
    final_report();
  end
endmodule
